// ### hdl/strap_cfg_pkg.sv
package strap_cfg_pkg;
  // Register bus geometry: upper nibble of the address selects the unit
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned UNIT_LSB   = 4;
  // Register indices (the index is the low nibble of the address)
  localparam logic [3:0]  REG_STAT   = 4'h0;
  localparam logic [3:0]  REG_MASK   = 4'h1;
  localparam logic [3:0]  REG_STRAP  = 4'h2;
  localparam logic [3:0]  REG_LED    = 4'h3;
  localparam logic [3:0]  REG_RESULT = 4'h4;
  localparam logic [3:0]  REG_FCTRL  = 4'h5;
  // Status and mask bit positions
  localparam int unsigned EV_SEQ     = 0;
  localparam int unsigned EV_RES     = 1;
  localparam int unsigned EV_OVF     = 2;
  localparam int unsigned EV_N       = 3;
  // Field positions
  localparam int unsigned STRAP_MODE_LSB = 4;
  localparam int unsigned LED_ST_LSB     = 4;
  localparam int unsigned FCTRL_EN       = 0;
  localparam int unsigned FCTRL_CLR      = 1;
  // Reset values
  localparam logic [EV_N-1:0] MASK_RST   = 3'h0;
  localparam logic            FEN_RST    = 1'b0;
  // Status flash codes
  localparam logic [1:0]  CODE_OK    = 2'h1;
  localparam logic [1:0]  CODE_SIG   = 2'h2;
  localparam logic [1:0]  CODE_BATT  = 2'h3;
  // Filter framing
  localparam logic [7:0]  TERM_CHAR  = 8'h0D;
  localparam logic [7:0]  DIGIT_0    = 8'h30;
  localparam logic [7:0]  DIGIT_9    = 8'h39;
  // Timing
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned FLASH_ON_MS = 1000;
  localparam int unsigned FLASH_OFF_MS = 1000;
  localparam int unsigned START_MS    = 1000;
  localparam int unsigned MAX_START_MS = 4000;
  localparam int unsigned FLASH_ON_CYC  = FLASH_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_OFF_CYC = FLASH_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned START_CYC     = START_MS * (CLK_HZ / 1000);
  typedef enum logic [1:0] {
    ST_START = 2'h0,
    ST_LIT   = 2'h1,
    ST_DARK  = 2'h3,
    ST_DONE  = 2'h2
  } led_st_t;
endpackage

// ### hdl/strap_config_status_led.sv
module strap_config_status_led #(
  parameter int unsigned ON_CYC    = strap_cfg_pkg::FLASH_ON_CYC,
  parameter int unsigned OFF_CYC   = strap_cfg_pkg::FLASH_OFF_CYC,
  parameter int unsigned START_CYC = strap_cfg_pkg::START_CYC
) (
  // Clock and reset
  input  wire logic                              sys_clk_i,
  input  wire logic                              rst_b_i,
  // Straps and health pins
  input  wire logic [3:0]                        addr_strap_i,
  input  wire logic [3:0]                        mode_strap_i,
  input  wire logic                              sig_fail_i,
  input  wire logic                              batt_low_i,
  // Received serial bytes
  input  wire logic                              rx_valid_i,
  input  wire logic [7:0]                        rx_byte_i,
  // Register bus
  input  wire logic [strap_cfg_pkg::ADDR_W-1:0]  bus_addr_i,
  input  wire logic [strap_cfg_pkg::DATA_W-1:0]  bus_wdata_i,
  input  wire logic                              bus_wr_i,
  input  wire logic                              bus_rd_i,
  output logic      [strap_cfg_pkg::DATA_W-1:0]  bus_rdata_o,
  // Indication
  output logic                                   led_o,
  output logic      [3:0]                        line_mode_o,
  output logic                                   irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for the strap and health pin inputs
  localparam int unsigned SYN_W = 10;
  logic [SYN_W-1:0] syn1_r;
  logic [SYN_W-1:0] syn2_r;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      syn1_r <= '0;
      syn2_r <= '0;
    end else begin
      syn1_r <= {batt_low_i, sig_fail_i, mode_strap_i, addr_strap_i};
      syn2_r <= syn1_r;
    end
  end
  wire logic [3:0] unit_addr = syn2_r[3:0];
  wire logic [3:0] mode_s    = syn2_r[7:4];
  wire logic       sig_s     = syn2_r[8];
  wire logic       batt_s    = syn2_r[9];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire logic [3:0] bus_unit = bus_addr_i[strap_cfg_pkg::ADDR_W-1:strap_cfg_pkg::UNIT_LSB];
  wire logic [3:0] bus_idx  = bus_addr_i[strap_cfg_pkg::UNIT_LSB-1:0];
  wire logic       unit_hit = (bus_unit == unit_addr);
  wire logic       wr_hit   = bus_wr_i && unit_hit;
  wire logic       rd_hit   = bus_rd_i && unit_hit;

  function automatic logic wr_to(input logic [3:0] idx, input logic [3:0] reg_idx);
    wr_to = (idx == reg_idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Status LED sequencer
  strap_cfg_pkg::led_st_t st_r;
  strap_cfg_pkg::led_st_t st_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [1:0]  code_r;
  logic [1:0]  flash_r;
  logic [1:0]  flash_nxt;
  logic        led_r;
  logic        seq_done;

  // A signature failure outranks a flat battery: the code memory is suspect first
  wire logic [1:0] code_pick = sig_s  ? strap_cfg_pkg::CODE_SIG  :
                               batt_s ? strap_cfg_pkg::CODE_BATT :
                                        strap_cfg_pkg::CODE_OK;
  wire logic start_end = (cnt_r == 32'(START_CYC - 1));
  wire logic on_end    = (cnt_r == 32'(ON_CYC - 1));
  wire logic off_end   = (cnt_r == 32'(OFF_CYC - 1));

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r + 32'h1;
    flash_nxt = flash_r;
    seq_done  = 1'b0;
    unique case (st_r)
      strap_cfg_pkg::ST_START: begin
        if (start_end) begin
          st_nxt  = strap_cfg_pkg::ST_LIT;
          cnt_nxt = 32'h0;
        end
      end
      strap_cfg_pkg::ST_LIT: begin
        if (on_end) begin
          st_nxt    = strap_cfg_pkg::ST_DARK;
          cnt_nxt   = 32'h0;
          flash_nxt = flash_r + 2'h1;
        end
      end
      strap_cfg_pkg::ST_DARK: begin
        if (off_end) begin
          cnt_nxt = 32'h0;
          if (flash_r == code_r) begin
            st_nxt   = strap_cfg_pkg::ST_DONE;
            seq_done = 1'b1;
          end else begin
            st_nxt = strap_cfg_pkg::ST_LIT;
          end
        end
      end
      strap_cfg_pkg::ST_DONE: begin
        cnt_nxt = 32'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r    <= strap_cfg_pkg::ST_START;
      cnt_r   <= 32'h0;
      flash_r <= 2'h0;
      code_r  <= strap_cfg_pkg::CODE_OK;
      led_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      flash_r <= flash_nxt;
      if (st_r == strap_cfg_pkg::ST_START && start_end) begin
        code_r <= code_pick;
      end
      led_r <= (st_nxt == strap_cfg_pkg::ST_LIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive filter: digits accumulate, the terminator ends a number, everything else is dropped
  logic        fen_r;
  logic [31:0] acc_r;
  logic        got_r;
  logic [31:0] result_r;
  wire logic   is_digit = (rx_byte_i >= strap_cfg_pkg::DIGIT_0) &&
                          (rx_byte_i <= strap_cfg_pkg::DIGIT_9);
  wire logic   is_term  = (rx_byte_i == strap_cfg_pkg::TERM_CHAR);
  wire logic   rx_take  = rx_valid_i && fen_r;
  wire logic [35:0] acc_mul = {4'h0, acc_r} * 36'hA +
                              {32'h0, rx_byte_i[3:0]};
  wire logic   acc_ovf  = |acc_mul[35:32];
  wire logic   res_ev   = rx_take && is_term && got_r;
  wire logic   ovf_ev   = rx_take && is_digit && acc_ovf;
  wire logic   fclr     = wr_hit && wr_to(bus_idx, strap_cfg_pkg::REG_FCTRL) &&
                          bus_wdata_i[strap_cfg_pkg::FCTRL_CLR];

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fen_r    <= strap_cfg_pkg::FEN_RST;
      acc_r    <= 32'h0;
      got_r    <= 1'b0;
      result_r <= 32'h0;
    end else begin
      if (wr_hit && wr_to(bus_idx, strap_cfg_pkg::REG_FCTRL)) begin
        fen_r <= bus_wdata_i[strap_cfg_pkg::FCTRL_EN];
      end
      if (fclr || res_ev) begin
        acc_r <= 32'h0;
        got_r <= 1'b0;
      end else if (rx_take && is_digit) begin
        acc_r <= acc_mul[31:0];
        got_r <= 1'b1;
      end
      if (res_ev) begin
        result_r <= acc_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, mask, interrupt and read path
  logic [strap_cfg_pkg::EV_N-1:0] stat_r;
  logic [strap_cfg_pkg::EV_N-1:0] mask_r;
  logic [strap_cfg_pkg::DATA_W-1:0] rdata_r;
  logic [3:0] mode_r;
  logic       irq_r;
  wire logic [strap_cfg_pkg::EV_N-1:0] ev_set = {ovf_ev, res_ev, seq_done};
  wire logic [strap_cfg_pkg::EV_N-1:0] ev_clr =
    (wr_hit && wr_to(bus_idx, strap_cfg_pkg::REG_STAT)) ?
    bus_wdata_i[strap_cfg_pkg::EV_N-1:0] : '0;
  // Set wins over a clear in the same cycle so no event is lost
  wire logic [strap_cfg_pkg::EV_N-1:0] stat_nxt = (stat_r & ~ev_clr) | ev_set;
  wire logic [strap_cfg_pkg::EV_N-1:0] mask_nxt =
    (wr_hit && wr_to(bus_idx, strap_cfg_pkg::REG_MASK)) ?
    bus_wdata_i[strap_cfg_pkg::EV_N-1:0] : mask_r;
  wire logic [strap_cfg_pkg::DATA_W-1:0] rd_val =
    (bus_idx == strap_cfg_pkg::REG_STAT)   ? 32'(stat_r) :
    (bus_idx == strap_cfg_pkg::REG_MASK)   ? 32'(mask_r) :
    (bus_idx == strap_cfg_pkg::REG_STRAP)  ? 32'({mode_s, unit_addr}) :
    (bus_idx == strap_cfg_pkg::REG_LED)    ? 32'({st_r, flash_r, code_r}) :
    (bus_idx == strap_cfg_pkg::REG_RESULT) ? result_r :
    (bus_idx == strap_cfg_pkg::REG_FCTRL)  ? 32'(fen_r) : 32'h0;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_r  <= '0;
      mask_r  <= strap_cfg_pkg::MASK_RST;
      rdata_r <= 32'h0;
      mode_r  <= 4'h0;
      irq_r   <= 1'b0;
    end else begin
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      rdata_r <= rd_hit ? rd_val : 32'h0;
      mode_r  <= mode_s;
      irq_r   <= |(stat_nxt & mask_nxt);
    end
  end

  assign bus_rdata_o = rdata_r;
  assign led_o       = led_r;
  assign line_mode_o = mode_r;
  assign irq_o       = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  // Lit and dark run lengths, and rises seen since reset
  // Dark count may wrap long after the sequence; only a rise reads it
  logic [31:0] lit_cnt_r;
  logic [31:0] dark_cnt_r;
  logic [1:0]  seen_r;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lit_cnt_r  <= 32'h0;
      dark_cnt_r <= 32'h0;
      seen_r     <= 2'h0;
    end else begin
      lit_cnt_r  <= led_r ? lit_cnt_r + 32'h1 : 32'h0;
      dark_cnt_r <= led_r ? 32'h0 : dark_cnt_r + 32'h1;
      if ($rose(led_r)) begin
        seen_r <= seen_r + 2'h1;
      end
    end
  end

  strap_addr_a: assert property (
    bus_rd_i && unit_hit && bus_idx == strap_cfg_pkg::REG_STRAP
    |=> bus_rdata_o[3:0] == $past(unit_addr))
    else $error("strap address readback wrong");
  foreign_rd_a: assert property (
    (bus_rd_i && !unit_hit) || !bus_rd_i |=> bus_rdata_o == 32'h0)
    else $error("read data driven for a foreign address");
  port_mode_a: assert property (
    $stable(mode_s) [*2] |-> line_mode_o == mode_s)
    else $error("line mode does not follow its strap");
  code_pick_a: assert property (
    st_r == strap_cfg_pkg::ST_DARK && st_nxt == strap_cfg_pkg::ST_DONE
    |-> seen_r == code_r)
    else $error("flash count differs from status code");
  flash_on_a: assert property (
    $fell(led_o) |-> lit_cnt_r == 32'(ON_CYC))
    else $error("flash lit time wrong");
  start_dark_a: assert property (
    st_r == strap_cfg_pkg::ST_START |-> !led_o && cnt_r < 32'(START_CYC))
    else $error("LED lit before the start delay ends");
  filter_result_a: assert property (
    res_ev && !fclr |=> result_r == $past(acc_r) && stat_r[strap_cfg_pkg::EV_RES])
    else $error("filter result not captured");
  led_off_done_a: assert property (
    st_r == strap_cfg_pkg::ST_DONE ##1 st_r == strap_cfg_pkg::ST_DONE |-> !led_o)
    else $error("LED lit after the sequence");
  done_quiet_a: assert property (
    st_r == strap_cfg_pkg::ST_DONE |-> seen_r == code_r)
    else $error("extra flash after the sequence");
  flash_off_a: assert property (
    $rose(led_o) && seen_r != 2'h0 |-> dark_cnt_r == 32'(OFF_CYC))
    else $error("flash dark time wrong");
  start_len_a: assert property (
    $rose(led_o) && seen_r == 2'h0 |-> dark_cnt_r == 32'(START_CYC))
    else $error("start delay length wrong");
  foreign_wr_a: assert property (
    bus_wr_i && !unit_hit |=> $stable(mask_r) && $stable(fen_r))
    else $error("write taken for a foreign address");
  ovf_flag_a: assert property (
    ovf_ev |=> stat_r[strap_cfg_pkg::EV_OVF])
    else $error("overflow not flagged");
  stat_sticky_a: assert property (
    (|ev_set) |=> (stat_r & $past(ev_set)) == $past(ev_set))
    else $error("status event lost");
  irq_level_a: assert property (
    irq_o == |(stat_r & mask_r))
    else $error("interrupt level wrong");

endmodule

// ### dv/host_model.sv
module host_model (
  // Clock
  input  wire logic        sys_clk_i,
  // Register bus master
  output logic      [7:0]  bus_addr_o,
  output logic      [31:0] bus_wdata_o,
  output logic             bus_wr_o,
  output logic             bus_rd_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    bus_addr_o  = 8'h00;
    bus_wdata_o = 32'h0;
    bus_wr_o    = 1'b0;
    bus_rd_o    = 1'b0;
  end

  // One word per strobe: stored strings are named, never sent whole
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    bus_addr_o  <= a;
    bus_wdata_o <= d;
    bus_wr_o    <= wr;
    bus_rd_o    <= !wr;
    @(posedge sys_clk_i);
  endtask

  // Both strobes drop here; xfer also drops the strobe it does not raise, so back-to-back transfers never double-assign
  task automatic idle();
    bus_wr_o <= 1'b0;
    bus_rd_o <= 1'b0;
    @(posedge sys_clk_i);
  endtask
endmodule

// ### dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ON = 20;
  localparam int OFF = 20;
  localparam int ST = 10;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  astr = 4'h0;
  logic [3:0]  mstr = 4'h0;
  logic        sig_fail = 1'b0;
  logic        batt_low = 1'b0;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_byte = 8'h00;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [31:0] rdata;
  logic        led;
  logic [3:0]  line_mode;
  logic        irq;
  logic [31:0] exp_q[$];
  logic        rd_seen = 1'b0;
  logic        led_d = 1'b0;
  logic [31:0] lit = 32'h0;
  logic [31:0] rises = 32'h0;
  logic [31:0] since = 32'h0;
  int          cyc = 0;
  int          checked = 0;
  int          bad_count = 0;
  logic [3:0]  d1;
  logic [3:0]  d2;

  always #5 clk = ~clk;

  host_model host (.sys_clk_i(clk), .bus_addr_o(bus_addr), .bus_wdata_o(bus_wdata),
                   .bus_wr_o(bus_wr), .bus_rd_o(bus_rd));

  strap_config_status_led #(.ON_CYC(ON), .OFF_CYC(OFF), .START_CYC(ST)) uut (
    .sys_clk_i(clk), .rst_b_i(rst_b), .addr_strap_i(astr), .mode_strap_i(mstr),
    .sig_fail_i(sig_fail), .batt_low_i(batt_low), .rx_valid_i(rx_valid),
    .rx_byte_i(rx_byte), .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata),
    .bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_rdata_o(rdata), .led_o(led),
    .line_mode_o(line_mode), .irq_o(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic rd(input logic [3:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, {astr, idx}, 32'h0);
  endtask

  task automatic send(input logic [7:0] b);
    rx_byte  <= b;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic do_reset(input int code);
    rst_b    <= 1'b0;
    sig_fail <= (code == 2);
    batt_low <= (code == 3);
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_seen <= bus_rd;
    if (rd_seen)
      chk(rdata, exp_q.pop_front());
  end

  // Flash counting and lit-width measurement
  always @(posedge clk) begin
    led_d <= led;
    if (!rst_b) begin
      rises <= 32'h0;
      lit   <= 32'h0;
      since <= 32'h0;
    end else begin
      since <= since + 32'h1;
      if (led) begin
        lit <= lit + 32'h1;
        if (!led_d) begin
          rises <= rises + 32'h1;
          if (rises == 32'h0)
            chk({31'h0, since >= ST && since <= ST + 2}, 32'h1);
        end
      end else if (led_d) begin
        chk(lit, ON);
        lit <= 32'h0;
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      $display("FAIL %0t run hung", $time);
      stop_test();
    end
  end

  initial begin
    void'($urandom(32'hda52));
    astr <= 4'($urandom_range(15));
    mstr <= 4'($urandom_range(15));
    d1   = 4'($urandom_range(9));
    d2   = 4'($urandom_range(9));
    for (int c = 3; c >= 1; c--) begin
      do_reset(c);
      rd(strap_cfg_pkg::REG_MASK, 32'h0);
      rd(strap_cfg_pkg::REG_FCTRL, 32'h0);
      host.idle();
      repeat (ST + c * (ON + OFF) + 5) @(posedge clk);
      chk(rises, c);
      repeat (60) @(posedge clk);
      chk(rises, c);
      chk({31'h0, led}, 32'h0);
      rd(strap_cfg_pkg::REG_LED, 32'({strap_cfg_pkg::ST_DONE, 2'(c), 2'(c)}));
      host.idle();
      $display("Flash code %0d test done", c);
    end
    // Strap decode and unit selection
    chk({28'h0, line_mode}, {28'h0, mstr});
    rd(strap_cfg_pkg::REG_STRAP, {24'h0, mstr, astr});
    exp_q.push_back(32'h0);
    host.xfer(1'b0, {astr ^ 4'h5, strap_cfg_pkg::REG_STRAP}, 32'h0);
    rd(4'hF, 32'h0);
    host.xfer(1'b1, {astr ^ 4'h9, strap_cfg_pkg::REG_MASK}, 32'h1);
    rd(strap_cfg_pkg::REG_MASK, 32'h0);
    host.idle();
    $display("Strap test done");
    // Sticky event, masking and write-one clear
    chk({31'h0, irq}, 32'h0);
    host.xfer(1'b1, {astr, strap_cfg_pkg::REG_MASK}, 32'h1);
    host.idle();
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    host.xfer(1'b1, {astr, strap_cfg_pkg::REG_STAT}, 32'h1);
    rd(strap_cfg_pkg::REG_STAT, 32'h0);
    host.idle();
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("Interrupt test done");
    // Configure, feed sensor data, then collect
    host.xfer(1'b1, {astr, strap_cfg_pkg::REG_FCTRL}, 32'h1);
    host.idle();
    send(strap_cfg_pkg::DIGIT_0 + 8'(d1));
    send(8'h41);
    send(strap_cfg_pkg::DIGIT_0 + 8'(d2));
    send(strap_cfg_pkg::TERM_CHAR);
    rd(strap_cfg_pkg::REG_RESULT, 32'(d1) * 32'd10 + 32'(d2));
    rd(strap_cfg_pkg::REG_STAT, 32'h2);
    // Clear drops a half-read number, so a lone terminator gives nothing
    host.xfer(1'b1, {astr, strap_cfg_pkg::REG_STAT}, 32'h2);
    host.idle();
    send(strap_cfg_pkg::DIGIT_9);
    host.xfer(1'b1, {astr, strap_cfg_pkg::REG_FCTRL}, 32'h3);
    host.idle();
    send(strap_cfg_pkg::TERM_CHAR);
    rd(strap_cfg_pkg::REG_STAT, 32'h0);
    host.idle();
    repeat (10) send(strap_cfg_pkg::DIGIT_9);
    rd(strap_cfg_pkg::REG_STAT, 32'h4);
    host.idle();
    repeat (2) @(posedge clk);
    $display("Filter test done");
    stop_test();
  end
endmodule
